// ==== hw/status_pin_selector.sv ====
// Purpose: Control register and driver for the first status pin
// Assumes: APB slave, no wait states; ready rises with the access phase
// Notes:   Test override takes the pin ahead of select and polarity
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module status_pin_selector
(
   input  wire logic                        clk_i,
   input  wire logic                        reset_n_i,
   input  wire logic                        psel_i,
   input  wire logic                        penable_i,
   input  wire logic                        pwrite_i,
   input  wire logic [7:0]                  paddr_i,
   input  wire logic [31:0]                 pwdata_i,
   output logic      [31:0]                 prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   input  wire status_pin_pkg::indicators_t ind_i,
   output logic                             first_status_pin_o,
   output logic                             irq_o
);
   logic [3:0]                             sel;
   logic                                   pol;
   logic                                   test_ovr;
   logic                                   test_level;
   logic [status_pin_pkg::EV_W-1:0]        irq_status;
   logic [status_pin_pkg::EV_W-1:0]        irq_enable;
   logic                                   raw_prev;
   logic [1:0]                             switch_prev;
   logic [3:0]                             next_sel;
   logic                                   next_pol;
   logic                                   next_test_ovr;
   logic                                   next_test_level;
   logic [status_pin_pkg::EV_W-1:0]        next_irq_status;
   logic [status_pin_pkg::EV_W-1:0]        next_irq_enable;
   logic [31:0]                            next_prdata;
   logic                                   next_pready;
   logic                                   next_pslverr;
   logic                                   next_pin;
   logic                                   next_irq;
   logic [status_pin_pkg::EV_W-1:0]        events;
   logic [status_pin_pkg::EV_W-1:0]        clear_mask;
   logic [status_pin_pkg::DIV_COUNT-1:0]   div_pulse;
   logic [status_pin_pkg::DIV_COUNT-1:0]   half;
   logic                                   raw;
   logic                                   setup;
   logic                                   wr_access;
   logic                                   mapped;

   // Halve each divider output pulse train
   assign div_pulse = {ind_i.m_pulse, ind_i.n_pulse, ind_i.r_pulse};

   generate
      for (genvar i = 0; i < status_pin_pkg::DIV_COUNT; i++)
      begin : g_div
         divide_by_two u_div
         (
            .clk_i     (clk_i),
            .reset_n_i (reset_n_i),
            .pulse_i   (div_pulse[i]),
            .half_o    (half[i])
         );
      end
   endgenerate

   // Indicator selection
   indicator_mux u_mux
   (
      .sel_i  (sel),
      .ind_i  (ind_i),
      .half_i (half),
      .raw_o  (raw)
   );

   // Bus phase decode
   assign setup     = psel_i && !penable_i;
   assign wr_access = psel_i && penable_i && pready_o && pwrite_i;
   assign mapped    = (paddr_i == status_pin_pkg::CTRL_ADDR)
                   || (paddr_i == status_pin_pkg::IRQ_STATUS_ADDR)
                   || (paddr_i == status_pin_pkg::IRQ_CLEAR_ADDR)
                   || (paddr_i == status_pin_pkg::IRQ_ENABLE_ADDR)
                   || (paddr_i == status_pin_pkg::TEST_CTRL_ADDR);

   // Register writes and read data
   always_comb
   begin
      next_sel        = sel;
      next_pol        = pol;
      next_test_ovr   = test_ovr;
      next_test_level = test_level;
      next_irq_enable = irq_enable;
      clear_mask      = '0;
      next_pready     = setup;
      next_pslverr    = setup && !mapped;
      next_prdata     = '0;
      if (wr_access)
      begin
         case (paddr_i)
            status_pin_pkg::CTRL_ADDR:
            begin
               next_sel = pwdata_i[status_pin_pkg::SEL_MSB:status_pin_pkg::SEL_LSB];
               next_pol = pwdata_i[status_pin_pkg::POL_BIT];
            end
            status_pin_pkg::IRQ_CLEAR_ADDR:
               clear_mask = pwdata_i[status_pin_pkg::EV_W-1:0];
            status_pin_pkg::IRQ_ENABLE_ADDR:
               next_irq_enable = pwdata_i[status_pin_pkg::EV_W-1:0];
            status_pin_pkg::TEST_CTRL_ADDR:
            begin
               next_test_ovr   = pwdata_i[status_pin_pkg::TEST_OVR_BIT];
               next_test_level = pwdata_i[status_pin_pkg::TEST_LEVEL_BIT];
            end
            default:
               clear_mask = '0;
         endcase
      end
      if (setup && !pwrite_i)
      begin
         case (paddr_i)
            status_pin_pkg::CTRL_ADDR:
               next_prdata = {24'h000000, sel, pol, 3'h0};
            status_pin_pkg::IRQ_STATUS_ADDR:
               next_prdata = {29'h00000000, irq_status};
            status_pin_pkg::IRQ_ENABLE_ADDR:
               next_prdata = {29'h00000000, irq_enable};
            status_pin_pkg::TEST_CTRL_ADDR:
               next_prdata = {30'h00000000, test_level, test_ovr};
            default:
               next_prdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sel        <= status_pin_pkg::SEL_RESET;
         pol        <= status_pin_pkg::POL_RESET;
         test_ovr   <= 1'b0;
         test_level <= 1'b0;
         irq_enable <= status_pin_pkg::EV_RESET;
         prdata_o   <= '0;
         pready_o   <= 1'b0;
         pslverr_o  <= 1'b0;
      end
      else
      begin
         sel        <= next_sel;
         pol        <= next_pol;
         test_ovr   <= next_test_ovr;
         test_level <= next_test_level;
         irq_enable <= next_irq_enable;
         prdata_o   <= next_prdata;
         pready_o   <= next_pready;
         pslverr_o  <= next_pslverr;
      end
   end

   // Event capture; a new event wins over a clear in the same cycle
   always_comb
   begin
      events = '0;
      events[status_pin_pkg::EV_ASSERT]  = raw && !raw_prev;
      events[status_pin_pkg::EV_SWITCH1] = ind_i.switch_back[0] && !switch_prev[0];
      events[status_pin_pkg::EV_SWITCH2] = ind_i.switch_back[1] && !switch_prev[1];
      next_irq_status = (irq_status & ~clear_mask) | events;
      next_irq        = |(next_irq_status & next_irq_enable);
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         irq_status  <= status_pin_pkg::EV_RESET;
         irq_o       <= 1'b0;
         raw_prev    <= 1'b0;
         switch_prev <= 2'h0;
      end
      else
      begin
         irq_status  <= next_irq_status;
         irq_o       <= next_irq;
         raw_prev    <= raw;
         switch_prev <= ind_i.switch_back;
      end
   end

   // Pin drive: override first, then polarity applied to the selection
   always_comb
   begin
      if (test_ovr)
         next_pin = test_level;
      else
         next_pin = raw ~^ pol;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         first_status_pin_o <= 1'b0;
      else
         first_status_pin_o <= next_pin;
   end

   // Checks on the pin and register behaviour
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_sel_write: assert property (
      (wr_access && paddr_i == status_pin_pkg::CTRL_ADDR)
      |=> (sel == $past(pwdata_i[7:4])) && (pol == $past(pwdata_i[3])))
      else $error("select or polarity not taken from write");

   a_reset_defaults: assert property (
      $rose(reset_n_i) |-> (sel == 4'h5) && pol)
      else $error("control register reset value wrong");

   a_pri_los_path: assert property (
      (!test_ovr && sel == 4'h0)
      |=> first_status_pin_o == ($past(ind_i.pri_los) ~^ $past(pol)))
      else $error("primary loss of signal not on pin");

   a_sec_los_path: assert property (
      (!test_ovr && sel == 4'h1)
      |=> first_status_pin_o == ($past(ind_i.sec_los) ~^ $past(pol)))
      else $error("secondary loss of signal not on pin");

   a_lol_paths: assert property (
      (!test_ovr && (sel == 4'h2 || sel == 4'h5))
      |=> first_status_pin_o
          == ($past(sel == 4'h2 ? ind_i.loss_of_lock[0] : ind_i.loss_of_lock[1]) ~^ $past(pol)))
      else $error("loss of lock not on pin");

   a_r_div_path: assert property (
      (!test_ovr && sel == 4'h3)
      |=> first_status_pin_o
          == (($past(half[0]) && !$past(ind_i.r_bypass[0])) ~^ $past(pol)))
      else $error("halved R divider not on pin");

   a_n_div_toggle: assert property (
      (ind_i.n_pulse[1] && !test_ovr && sel == 4'h7)
      ##1 (!test_ovr && sel == 4'h7)
      |=> first_status_pin_o != $past(first_status_pin_o) || $past(pol) != $past(pol, 2))
      else $error("N divider pulse did not toggle pin");

   a_m_bypass_idle: assert property (
      (!test_ovr && sel == 4'hc && ind_i.m_bypass[1])
      |=> first_status_pin_o == !$past(pol))
      else $error("bypassed M divider not inactive");

   a_busy_paths: assert property (
      (!test_ovr && pol && sel == 4'hd) |=> first_status_pin_o == $past(ind_i.nvm_active))
      else $error("memory busy not on pin");

   a_irq_path: assert property (
      (!test_ovr && !pol && sel == 4'ha)
      |=> first_status_pin_o == !$past(ind_i.irq_summary))
      else $error("interrupt summary not on pin");

   a_switch_path: assert property (
      (!test_ovr && sel == 4'he && ind_i.switch_back[0])
      |=> first_status_pin_o == $past(pol))
      else $error("switch back not on pin");

   a_test_override: assert property (
      test_ovr |=> first_status_pin_o == $past(test_level))
      else $error("test override not applied");

   a_reserved_zero: assert property (
      (setup && !pwrite_i && paddr_i == status_pin_pkg::CTRL_ADDR)
      |=> pready_o && (prdata_o[2:0] == 3'h0))
      else $error("reserved bits not zero");

   a_irq_level: assert property (
      irq_o == |(irq_status & irq_enable))
      else $error("interrupt output disagrees with status");

   // Every event latches its status bit, even against a clear in the same cycle
   a_event_sticky: assert property (
      (|events) |=> ((irq_status & $past(events)) == $past(events)))
      else $error("event did not set its status bit");

   a_clear_status: assert property (
      (wr_access && paddr_i == status_pin_pkg::IRQ_CLEAR_ADDR)
      |=> ((irq_status & $past(pwdata_i[2:0]) & ~$past(events)) == 3'h0))
      else $error("cleared status bit still set");

   c_low_polarity: cover property (!pol && !test_ovr && !first_status_pin_o);
   c_div_select: cover property (sel == 4'h4 ##1 ind_i.n_pulse[0]);
   c_override: cover property (test_ovr && test_level);
   c_irq_raised: cover property ($rose(irq_o));
endmodule

// ==== hw/status_pin_pkg.sv ====
// Purpose: Shared constants and carriers for the status pin selector
// Assumes: APB slave with 32-bit data; 8-bit byte address
// Notes:   Index 0 of two-element fields is the first synthesizer
package status_pin_pkg;
   // Byte addresses of the registers
   localparam logic [7:0] CTRL_INDEX       = 8'h1b;
   localparam logic [7:0] CTRL_ADDR        = {CTRL_INDEX[5:0], 2'b00};
   localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h70;
   localparam logic [7:0] IRQ_CLEAR_ADDR   = 8'h74;
   localparam logic [7:0] IRQ_ENABLE_ADDR  = 8'h78;
   localparam logic [7:0] TEST_CTRL_ADDR   = 8'h7c;

   // Control register fields and reset values
   localparam int unsigned SEL_MSB   = 7;
   localparam int unsigned SEL_LSB   = 4;
   localparam int unsigned POL_BIT   = 3;
   localparam logic [3:0]  SEL_RESET = 4'h5;
   localparam logic        POL_RESET = 1'b1;

   // Test control fields
   localparam int unsigned TEST_OVR_BIT   = 0;
   localparam int unsigned TEST_LEVEL_BIT = 1;

   // Interrupt event bits
   localparam int unsigned EV_ASSERT  = 0;
   localparam int unsigned EV_SWITCH1 = 1;
   localparam int unsigned EV_SWITCH2 = 2;
   localparam int unsigned EV_W       = 3;
   localparam logic [EV_W-1:0] EV_RESET = 3'h0;

   // Divider slots: R at 0..1, N at 2..3, M at 4..5
   localparam int unsigned DIV_COUNT = 6;
   localparam int unsigned DIV_R     = 0;
   localparam int unsigned DIV_N     = 2;
   localparam int unsigned DIV_M     = 4;

   // Source select codes
   typedef enum logic [3:0] {
      SRC_PRI_LOS   = 4'h0,
      SRC_SEC_LOS   = 4'h1,
      SRC_LOL1      = 4'h2,
      SRC_R1        = 4'h3,
      SRC_N1        = 4'h4,
      SRC_LOL2      = 4'h5,
      SRC_R2        = 4'h6,
      SRC_N2        = 4'h7,
      SRC_CAL1      = 4'h8,
      SRC_CAL2      = 4'h9,
      SRC_IRQ       = 4'ha,
      SRC_M1        = 4'hb,
      SRC_M2        = 4'hc,
      SRC_NVM       = 4'hd,
      SRC_SWITCH1   = 4'he,
      SRC_SWITCH2   = 4'hf
   } source_code_t;

   // Internal indicators feeding the selector
   typedef struct packed {
      logic       pri_los;
      logic       sec_los;
      logic [1:0] loss_of_lock;
      logic [1:0] r_pulse;
      logic [1:0] n_pulse;
      logic [1:0] m_pulse;
      logic [1:0] r_bypass;
      logic [1:0] m_bypass;
      logic [1:0] cal_active;
      logic       nvm_active;
      logic       irq_summary;
      logic [1:0] switch_back;
   } indicators_t;
endpackage

// ==== hw/divide_by_two.sv ====
// Purpose: Halves the rate of a divider output pulse train
// Assumes: Pulse input is one cycle wide per divider output edge
// Notes:   Output is a square wave at half the pulse rate
`timescale 1ns/1ps
module divide_by_two
(
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic pulse_i,
   output logic      half_o
);
   logic next_half;

   // Toggle on each divider pulse
   always_comb
   begin
      next_half = half_o ^ pulse_i;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         half_o <= 1'b0;
      else
         half_o <= next_half;
   end
endmodule

// ==== hw/indicator_mux.sv ====
// Purpose: Picks one of sixteen indicators for the status pin
// Assumes: Halved divider outputs come from divide_by_two instances
// Notes:   A bypassed R or M divider gives an inactive indication
`timescale 1ns/1ps
module indicator_mux
(
   input  wire logic                               [3:0] sel_i,
   input  wire status_pin_pkg::indicators_t              ind_i,
   input  wire logic [status_pin_pkg::DIV_COUNT-1:0]     half_i,
   output logic                                          raw_o
);
   // Source selection by code
   always_comb
   begin
      case (status_pin_pkg::source_code_t'(sel_i))
         status_pin_pkg::SRC_PRI_LOS: raw_o = ind_i.pri_los;
         status_pin_pkg::SRC_SEC_LOS: raw_o = ind_i.sec_los;
         status_pin_pkg::SRC_LOL1:    raw_o = ind_i.loss_of_lock[0];
         status_pin_pkg::SRC_LOL2:    raw_o = ind_i.loss_of_lock[1];
         status_pin_pkg::SRC_R1:      raw_o = half_i[status_pin_pkg::DIV_R] & ~ind_i.r_bypass[0];
         status_pin_pkg::SRC_R2:      raw_o = half_i[status_pin_pkg::DIV_R+1] & ~ind_i.r_bypass[1];
         status_pin_pkg::SRC_N1:      raw_o = half_i[status_pin_pkg::DIV_N];
         status_pin_pkg::SRC_N2:      raw_o = half_i[status_pin_pkg::DIV_N+1];
         status_pin_pkg::SRC_M1:      raw_o = half_i[status_pin_pkg::DIV_M] & ~ind_i.m_bypass[0];
         status_pin_pkg::SRC_M2:      raw_o = half_i[status_pin_pkg::DIV_M+1] & ~ind_i.m_bypass[1];
         status_pin_pkg::SRC_CAL1:    raw_o = ind_i.cal_active[0];
         status_pin_pkg::SRC_CAL2:    raw_o = ind_i.cal_active[1];
         status_pin_pkg::SRC_NVM:     raw_o = ind_i.nvm_active;
         status_pin_pkg::SRC_IRQ:     raw_o = ind_i.irq_summary;
         status_pin_pkg::SRC_SWITCH1: raw_o = ind_i.switch_back[0];
         status_pin_pkg::SRC_SWITCH2: raw_o = ind_i.switch_back[1];
         default:                     raw_o = 1'b0;
      endcase
   end
endmodule

// ==== dv/status_pin_board.sv ====
// Purpose: Board side watcher of the first status pin
// Assumes: Pin is a registered level, sampled on the rising edge
// Notes:   Counts pin changes so the bench can check halved divider rates
`timescale 1ns/1ps
module status_pin_board
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        pin_i,
   output logic      [15:0] edges_o
);
   logic last;

   // Count every change of the pin level
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         last    <= 1'b0;
         edges_o <= 16'h0000;
      end
      else
      begin
         last <= pin_i;
         if (pin_i !== last)
            edges_o <= edges_o + 16'h0001;
      end
   end
endmodule

// ==== dv/tb_status_pin_selector.sv ====
// Purpose: Self-checking bench for the status pin selector
// Assumes: APB answers after a bounded wait; pin has one cycle latency
// Notes:   Reads and writes are noted in a queue and checked by a watcher process
`timescale 1ns/1ps
module tb_status_pin_selector;
   logic                        clk_i, reset_n_i, psel, penable, pwrite;
   logic [7:0]                  paddr;
   logic [31:0]                 pwdata, prdata;
   logic                        pready, pslverr, pin, irq;
   status_pin_pkg::indicators_t ind, v;
   logic [15:0]                 edges, e0;
   logic [32:0]                 exp_q[$];
   logic [32:0]                 e;
   int                          n_mismatch, cmp_count, seed, cycles;
   int                          lv[10] = '{0, 1, 2, 5, 8, 9, 10, 13, 14, 15};
   int                          dv[6] = '{3, 4, 6, 7, 11, 12};

   status_pin_selector i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ind_i(ind),
      .first_status_pin_o(pin), .irq_o(irq));
   status_pin_board i_board (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(pin),
      .edges_o(edges));

   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      cmp_count++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One APB transfer; the expected answer goes to the queue
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] x);
      exp_q.push_back(x);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      apb(1'b0, a, 32'h0, {1'b0, d});
   endtask

   task automatic pin_is(input logic want);
      repeat (3) @(posedge clk_i);
      check({31'h0, pin}, {31'h0, want}, "status pin");
   endtask

   function automatic logic [31:0] ctrl(input logic [3:0] c, input logic p);
      return {24'h0, c, p, 3'b000};
   endfunction

   // Raw indication that each level code selects
   function automatic logic exp_lvl(input logic [3:0] c, input status_pin_pkg::indicators_t s);
      case (c)
         4'h0: return s.pri_los;
         4'h1: return s.sec_los;
         4'h2: return s.loss_of_lock[0];
         4'h5: return s.loss_of_lock[1];
         4'h8: return s.cal_active[0];
         4'h9: return s.cal_active[1];
         4'ha: return s.irq_summary;
         4'hd: return s.nvm_active;
         4'he: return s.switch_back[0];
         4'hf: return s.switch_back[1];
         default: return 1'b0;
      endcase
   endfunction

   // One divider pulse on the input that the code selects
   task automatic pulse(input int c);
      case (c)
         3: ind.r_pulse[0] <= 1'b1;
         6: ind.r_pulse[1] <= 1'b1;
         4: ind.n_pulse[0] <= 1'b1;
         7: ind.n_pulse[1] <= 1'b1;
         11: ind.m_pulse[0] <= 1'b1;
         default: ind.m_pulse[1] <= 1'b1;
      endcase
      @(posedge clk_i);
      ind.r_pulse <= 2'b00;
      ind.n_pulse <= 2'b00;
      ind.m_pulse <= 2'b00;
      repeat (3) @(posedge clk_i);
   endtask

   // Clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Watcher: each answer is compared with the oldest note
   always @(posedge clk_i)
   begin
      if (psel && penable && pready === 1'b1)
      begin
         e = exp_q.pop_front();
         check({31'h0, pslverr}, {31'h0, e[32]}, "slave error");
         if (!pwrite)
            check(prdata, e[31:0], "read data");
      end
   end

   // Hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         $display("BAD %0t timeout", $time);
         final_report();
      end
   end

   initial
   begin
      seed = 7;
      reset_n_i = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      ind = '0;
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rd(status_pin_pkg::CTRL_ADDR, 32'h58);
      ind.loss_of_lock[1] <= 1'b1;
      pin_is(1'b1);
      wr(status_pin_pkg::CTRL_ADDR, 32'hff);
      rd(status_pin_pkg::CTRL_ADDR, 32'hf8);
      // Every level code, both polarities, random indicators
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < 10; i++)
         begin
            wr(status_pin_pkg::CTRL_ADDR, ctrl(lv[i][3:0], p[0]));
            repeat (3)
            begin
               v = status_pin_pkg::indicators_t'($random(seed));
               ind <= v;
               pin_is(exp_lvl(lv[i][3:0], v) ~^ p[0]);
            end
         end
      // Divider codes: four pulses give four pin changes; bypass holds inactive
      for (int i = 0; i < 6; i++)
         for (int b = 0; b < 2; b++)
         begin
            v = '0;
            v.r_bypass = {2{b[0]}};
            v.m_bypass = {2{b[0]}};
            ind <= v;
            wr(status_pin_pkg::CTRL_ADDR, ctrl(dv[i][3:0], 1'b1));
            repeat (3) @(posedge clk_i);
            e0 = edges;
            repeat (4) pulse(dv[i]);
            if (b == 0 || dv[i] == 4 || dv[i] == 7)
               check({16'h0, edges - e0}, 32'h4, "halved divider");
            else
            begin
               check({16'h0, edges - e0}, 32'h0, "bypassed divider");
               pin_is(1'b0);
            end
         end
      // Test override beats select and polarity
      ind <= '0;
      wr(status_pin_pkg::CTRL_ADDR, ctrl(4'h2, 1'b0));
      // Normal level is high here, so a forced low shows the override
      wr(status_pin_pkg::TEST_CTRL_ADDR, 32'h1);
      pin_is(1'b0);
      rd(status_pin_pkg::TEST_CTRL_ADDR, 32'h1);
      // Normal level turns low, so a forced high shows the override
      ind.loss_of_lock[0] <= 1'b1;
      wr(status_pin_pkg::TEST_CTRL_ADDR, 32'h3);
      pin_is(1'b1);
      wr(status_pin_pkg::TEST_CTRL_ADDR, 32'h0);
      pin_is(1'b0);
      // Interrupts: raise, mask, unmask, clear
      wr(status_pin_pkg::IRQ_CLEAR_ADDR, 32'h7);
      rd(status_pin_pkg::IRQ_STATUS_ADDR, 32'h0);
      wr(status_pin_pkg::IRQ_ENABLE_ADDR, 32'h2);
      rd(status_pin_pkg::IRQ_ENABLE_ADDR, 32'h2);
      ind.switch_back[0] <= 1'b1;
      repeat (3) @(posedge clk_i);
      check({31'h0, irq}, 32'h1, "irq raised");
      wr(status_pin_pkg::IRQ_STATUS_ADDR, 32'h0);
      rd(status_pin_pkg::IRQ_STATUS_ADDR, 32'h2);
      wr(status_pin_pkg::IRQ_ENABLE_ADDR, 32'h0);
      check({31'h0, irq}, 32'h0, "irq masked");
      wr(status_pin_pkg::IRQ_ENABLE_ADDR, 32'h7);
      check({31'h0, irq}, 32'h1, "irq unmasked");
      wr(status_pin_pkg::IRQ_CLEAR_ADDR, 32'h2);
      check({31'h0, irq}, 32'h0, "irq cleared");
      rd(status_pin_pkg::IRQ_CLEAR_ADDR, 32'h0);
      wr(status_pin_pkg::CTRL_ADDR, ctrl(4'h0, 1'b1));
      ind.pri_los <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(status_pin_pkg::IRQ_STATUS_ADDR, 32'h1);
      check({31'h0, irq}, 32'h1, "selected rise irq");
      // Unmapped addresses answer with an error
      apb(1'b0, 8'h00, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 8'h04, 32'h1, {1'b1, 32'h0});
      check({31'h0, exp_q.size() == 0}, 32'h1, "answers pending");
      final_report();
   end
endmodule
